/* File: rtl/art_lookup.sv */
// Notes on behaviour
// [R1] Five 16-bit entries are held per protocol/rate set; lookup inputs are range index and set.
// [R2] The entry picked is the one whose position equals the supply range index; the code clamps an index at or above the range count to the last range.
// [R3] Entry bit 15 clear applies settings always; set applies them only in the frame-delay window.
// [R4] For entry 0, bit 15 set also applies settings when the power loop changes the supply.
// [R5] Bits 14 to 10 of each entry are ignored; writers leave them zero.
// [R6] Bit 9 drives the receiver IIR filter enable.
// [R7] Bits 8 to 7 are written as matched-filter gain into the rx technology settings.
// [R8] Bits 6 to 0 are written as signal-detect threshold override into the signal strength reg.
// [R9] Settings take effect as soon as tuning is enabled, with no further trigger.
// [R10] Type A with tuning off needs a threshold above 0x50 at gain 2; a writer duty.
// [R11] Type A with tuning on and bit 15 clear needs the same threshold; a writer duty.
// [R12] A supply change from the power loop reruns the lookup and reloads the settings; a change arriving in the ART_APPLY cycle is dropped.
// [R13] The supply range index takes values 0 to 4.
// [R14] The number of ranges in use, at most five, comes from a 3-bit configuration field.
// [R15] Applied settings hold until the next lookup; disabling tuning drops the override but keeps them.
`timescale 1ns/1ns
`default_nettype none
`include "art_params.svh"

module art_lookup #(
	parameter int NUM_SETS = `ART_NUM_SETS
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [7:0]            addr,
	input  wire logic [31:0]           wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic      [31:0]           rdata,
	input  wire logic [2:0]            supply_range_index,
	input  wire logic [2:0]            protocol_rate_sel,
	input  wire logic                  supply_changed,
	input  wire logic                  frame_delay_window,
	output logic                       rx_settings_write,
	output art_pkg::art_settings_t     rx_settings,
	output logic                       rx_override_active
);

	localparam int DEPTH = NUM_SETS * `ART_ENTRIES_PER_SET;
	localparam int AW    = $clog2(DEPTH);

	// ***************************************
	// Register port
	// ***************************************
	logic                   tuning_en_reg, tuning_en_next;
	logic [2:0]             range_cnt_reg, range_cnt_next;
	logic [AW-1:0]          sel_reg, sel_next;
	logic [31:0]            rdata_reg, rdata_next;
	logic                   tbl_wr;
	logic [15:0]            mem_rd;
	logic [AW-1:0]          mem_ra;

	assign tbl_wr = wr && (addr == `ART_ADDR_ENTRY_DATA);

	// ***************************************
	// Lookup engine
	// ***************************************
	art_pkg::art_state_t    st_reg, st_next;
	logic [15:0]            entry_reg, entry_next;
	logic [2:0]             idx_reg, idx_next;
	logic                   valid_reg, valid_next;
	logic                   en_d_reg;
	art_pkg::art_settings_t set_reg, set_next;
	logic                   act_reg, act_next;
	logic                   wstb_reg, wstb_next;
	logic                   chg_hold_reg, chg_hold_next;
	logic                   pend_reg, pend_next;

	function automatic logic [2:0] clamp_index(input logic [2:0] idx, input logic [2:0] cnt);
		logic [2:0] lim;
		lim = (cnt == 3'h0 || cnt > 3'h5) ? 3'h5 : cnt; // R14
		clamp_index = (idx >= lim) ? lim - 3'h1 : idx; // R13
	endfunction

	function automatic logic [AW-1:0] entry_addr(input logic [2:0] set, input logic [2:0] idx);
		logic [31:0] a;
		a = 32'(set) * `ART_ENTRIES_PER_SET + 32'(idx); // R1
		entry_addr = a[AW-1:0];
	endfunction

	assign mem_ra = entry_addr(protocol_rate_sel,
		clamp_index(supply_range_index, range_cnt_reg)); // R2

	art_table_mem #(
		.DEPTH (DEPTH),
		.AW    (AW),
		.DW    (16)
	) u_mem (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (tbl_wr),
		.wr_addr (sel_reg),
		.wr_data (wdata[15:0]),
		.rd_addr (mem_ra),
		.rd_data (mem_rd)
	);

	always_comb begin
		tuning_en_next = tuning_en_reg;
		range_cnt_next = range_cnt_reg;
		sel_next       = sel_reg;
		rdata_next     = 32'h0;
		if (wr) begin
			case (addr)
				`ART_ADDR_CTRL: begin
					tuning_en_next = wdata[`ART_CTRL_EN_BIT];
					range_cnt_next = wdata[`ART_CTRL_CNT_MSB:`ART_CTRL_CNT_LSB]; // R14
				end
				`ART_ADDR_TABLE_SEL: begin
					sel_next = wdata[AW-1:0];
				end
				`ART_ADDR_ENTRY_DATA: begin
					sel_next = (32'(sel_reg) + 32'h1 >= DEPTH) ? '0 : sel_reg + AW'(1);
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			case (addr)
				`ART_ADDR_CTRL:      rdata_next = {28'h0, range_cnt_reg, tuning_en_reg};
				`ART_ADDR_STATUS:    rdata_next = {26'h0, act_reg, valid_reg, 1'b0, idx_reg};
				`ART_ADDR_TABLE_SEL: rdata_next = 32'(sel_reg);
				`ART_ADDR_ENTRY_DATA: rdata_next = {16'h0, entry_reg};
				`ART_ADDR_APPLIED:   rdata_next = {22'h0, set_reg};
				default:             rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tuning_en_reg <= 1'b0;
			range_cnt_reg <= `ART_CNT_RESET;
			sel_reg       <= '0;
			rdata_reg     <= 32'h0;
		end else begin
			tuning_en_reg <= tuning_en_next;
			range_cnt_reg <= range_cnt_next;
			sel_reg       <= sel_next;
			rdata_reg     <= rdata_next;
		end
	end

	// Lookup start: enable rise, supply change, or table write while enabled
	logic start;
	assign start = tuning_en_reg && (!en_d_reg || supply_changed || pend_reg); // R9 R12

	always_comb begin
		st_next       = st_reg;
		entry_next    = entry_reg;
		idx_next      = idx_reg;
		valid_next    = valid_reg;
		set_next      = set_reg;
		act_next      = act_reg;
		wstb_next     = 1'b0;
		chg_hold_next = chg_hold_reg;
		pend_next     = pend_reg || tbl_wr;
		case (st_reg)
			art_pkg::ART_IDLE: begin
				if (start) begin
					pend_next = tbl_wr;
					st_next   = art_pkg::ART_FETCH;
				end
			end
			art_pkg::ART_FETCH: begin
				// Memory read data is registered: one cycle of latency
				idx_next = clamp_index(supply_range_index, range_cnt_reg); // R2
				st_next  = art_pkg::ART_APPLY;
			end
			art_pkg::ART_APPLY: begin
				entry_next = mem_rd & 16'h83FF; // R5
				valid_next = 1'b1;
				set_next.iir_enable = mem_rd[`ART_ENT_IIR_BIT]; // R6
				set_next.matched_filter_gain =
					mem_rd[`ART_ENT_GAIN_MSB:`ART_ENT_GAIN_LSB]; // R7
				set_next.signal_detect_threshold_override =
					mem_rd[`ART_ENT_THR_MSB:`ART_ENT_THR_LSB]; // R8
				wstb_next = 1'b1;
				st_next   = art_pkg::ART_IDLE;
			end
			default: begin
				st_next = art_pkg::ART_IDLE;
			end
		endcase
		if (valid_reg && !entry_reg[`ART_ENT_WINDOW_BIT]) begin
			act_next = 1'b1; // R3
		end else if (valid_reg) begin
			act_next = frame_delay_window
				|| (idx_reg == 3'h0 && (supply_changed || chg_hold_reg)); // R3 R4
		end
		if (act_reg && !act_next) begin
			chg_hold_next = 1'b0;
		end
		// New supply change wins over the drop clear
		if (supply_changed) begin
			chg_hold_next = 1'b1; // R4
		end
		if (!tuning_en_reg) begin
			valid_next    = 1'b0; // R15
			act_next      = 1'b0;
			wstb_next     = 1'b0;
			chg_hold_next = 1'b0;
			st_next       = art_pkg::ART_IDLE;
			pend_next     = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg       <= art_pkg::ART_IDLE;
			entry_reg    <= 16'h0;
			idx_reg      <= 3'h0;
			valid_reg    <= 1'b0;
			en_d_reg     <= 1'b0;
			set_reg      <= '{1'b0, `ART_GAIN_RESET, `ART_THR_RESET};
			act_reg      <= 1'b0;
			wstb_reg     <= 1'b0;
			chg_hold_reg <= 1'b0;
			pend_reg     <= 1'b0;
		end else begin
			st_reg       <= st_next;
			entry_reg    <= entry_next;
			idx_reg      <= idx_next;
			valid_reg    <= valid_next;
			en_d_reg     <= tuning_en_reg;
			set_reg      <= set_next; // R15
			act_reg      <= act_next;
			wstb_reg     <= wstb_next;
			chg_hold_reg <= chg_hold_next;
			pend_reg     <= pend_next;
		end
	end

	assign rdata              = rdata_reg;
	assign rx_settings        = set_reg;
	assign rx_settings_write  = wstb_reg;
	assign rx_override_active = act_reg;

endmodule

`default_nettype wire

/* File: rtl/art_params.svh */
`ifndef ART_PARAMS_SVH
`define ART_PARAMS_SVH

// Register indices (word address = index * 4 on the plain port)
`define ART_ADDR_CTRL        8'h00
`define ART_ADDR_STATUS      8'h04
`define ART_ADDR_TABLE_SEL   8'h08
`define ART_ADDR_ENTRY_DATA  8'h0C
`define ART_ADDR_APPLIED     8'h10

// Control register fields
`define ART_CTRL_EN_BIT      0
`define ART_CTRL_CNT_LSB     1
`define ART_CTRL_CNT_MSB     3

// Entry field positions
`define ART_ENT_WINDOW_BIT   15
`define ART_ENT_IIR_BIT      9
`define ART_ENT_GAIN_MSB     8
`define ART_ENT_GAIN_LSB     7
`define ART_ENT_THR_MSB      6
`define ART_ENT_THR_LSB      0

// Reset values
`define ART_CNT_RESET        3'h5
`define ART_GAIN_RESET       2'h2
`define ART_THR_RESET        7'h00

// Table shape
`define ART_ENTRIES_PER_SET  5
`define ART_NUM_SETS         8

`endif

/* File: rtl/art_pkg.sv */
package art_pkg;

	typedef struct packed {
		logic       iir_enable;
		logic [1:0] matched_filter_gain;
		logic [6:0] signal_detect_threshold_override;
	} art_settings_t;

	typedef enum logic [2:0] {
		ART_IDLE  = 3'b001,
		ART_FETCH = 3'b010,
		ART_APPLY = 3'b100
	} art_state_t;

endpackage

/* File: rtl/art_table_mem.sv */
`timescale 1ns/1ns
`default_nettype none

module art_table_mem #(
	parameter int DEPTH = 40,
	parameter int AW    = 6,
	parameter int DW    = 16
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem_reg [DEPTH];
	logic [DW-1:0] rd_data_reg;

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_reg <= '0;
		end else begin
			rd_data_reg <= mem_reg[rd_addr];
		end
	end

	assign rd_data = rd_data_reg;

endmodule

`default_nettype wire

/* File: tb/art_lookup_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "art_params.svh"
module art_lookup_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [2:0] supply_range_index,
	input wire logic [2:0] protocol_rate_sel,
	input wire logic supply_changed,
	input wire logic frame_delay_window,
	input wire logic rx_settings_write,
	input wire art_pkg::art_settings_t rx_settings,
	input wire logic rx_override_active
);
	logic en_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Tuning enable as last written
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) en_q <= 1'b0;
		else if (wr && addr == `ART_ADDR_CTRL) en_q <= wdata[0];
	a_write_single: assert property (rx_settings_write |=> !rx_settings_write)
		else $error("pulse too long");
	a_settings_hold: assert property ($changed(rx_settings) |-> rx_settings_write)
		else $error("change without reload");
	a_reserved_zero: assert property ($past(rd) && $past(addr) == `ART_ADDR_ENTRY_DATA
		|-> rdata[14:10] == 5'h00) else $error("reserved bits read");
	a_reload_needs_en: assert property (rx_settings_write |-> en_q)
		else $error("reload while off");
	a_off_clears: assert property (!en_q && !$past(en_q) |-> !rx_override_active)
		else $error("active while off");
	a_enable_loads: assert property ($rose(en_q) |-> ##[1:6] rx_settings_write)
		else $error("no enable reload");
	a_supply_loads: assert property (en_q && $past(en_q) && supply_changed
		|-> ##[1:6] rx_settings_write) else $error("no supply reload");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("stray read data");
endmodule
bind art_lookup art_lookup_props u_props (.*);
`default_nettype wire

/* File: tb/art_rx_model.sv */
`timescale 1ns/1ns
`default_nettype none
module art_rx_model (
	input wire logic clk,
	input wire logic rx_settings_write,
	input wire art_pkg::art_settings_t rx_settings,
	output logic [2:0] supply_range_index,
	output logic supply_changed,
	output art_pkg::art_settings_t cap
);
	initial {supply_range_index, supply_changed} = 4'h0;
	// Receiver registers take each reload
	always @(posedge clk)
		if (rx_settings_write) cap <= rx_settings;
	task automatic change(input logic [2:0] i);
		@(posedge clk) supply_range_index <= i;
		supply_changed <= 1'b1;
		@(posedge clk) supply_changed <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tb/art_lookup_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "art_params.svh"
module art_lookup_tb_top;
	logic clk, rst_n, wr, rd, frame_delay_window, supply_changed;
	logic rx_settings_write, rx_override_active;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] supply_range_index, protocol_rate_sel;
	logic [15:0] e;
	art_pkg::art_settings_t rx_settings, cap;
	int err_count, comparisons, n;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	art_lookup dut (.*);
	art_rx_model rx (.*);
	function automatic logic [15:0] ent(input int k);
		return {1'(k % 5 == 3 || k == 15), 5'h1F, 3'(k), 7'h51 + 7'(k)};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, s);
		end
	endtask
	task automatic close_out;
		if (err_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk) wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string nm);
		@(posedge clk) addr <= a;
		rd <= 1'b1;
		@(posedge clk) rd <= 1'b0;
		#1 chk(nm, rdata, x);
	endtask
	task automatic look(input int k, input logic z);
		for (n = 0; n < 12 && rx_settings_write !== 1'b1; n++) @(posedge clk) #1;
		@(posedge clk) #1 e = ent(k);
		chk("reload", 32'(n < 12), 32'h1);
		chk("settings", 32'(cap), 32'(e[9:0]));
		chk("active", 32'(rx_override_active), 32'(!e[15] || z));
	endtask
	initial begin
		#20000 err_count++;
		close_out;
	end
	initial begin
		{rst_n, wr, rd, frame_delay_window} = 4'h0;
		{addr, wdata} = 40'h0;
		protocol_rate_sel = 3'h2;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rchk(`ART_ADDR_CTRL, 32'h0000000A, "ctrl");
		rchk(`ART_ADDR_APPLIED, 32'h00000100, "applied");
		rchk(8'h20, 32'h0, "unmapped");
		wreg(`ART_ADDR_TABLE_SEL, 32'h0);
		for (int k = 0; k < 40; k++)
			wreg(`ART_ADDR_ENTRY_DATA, 32'(ent(k)));
		rchk(`ART_ADDR_TABLE_SEL, 32'h0, "sel_wrap");
		wreg(`ART_ADDR_CTRL, 32'h0000000B);
		look(10, 1'b1);
		for (int s = 2; s < 4; s++) begin
			protocol_rate_sel <= 3'(s);
			for (int i = 0; i < 5; i++) begin
				rx.change(3'(i));
				look(s * 5 + i, i == 0);
				frame_delay_window <= 1'b1;
				repeat (2) @(posedge clk);
				#1 chk("window", 32'(rx_override_active), 32'h1);
				frame_delay_window <= 1'b0;
			end
		end
		wreg(`ART_ADDR_CTRL, 32'h00000007);
		rx.change(3'h4);
		look(17, 1'b0);
		rchk(`ART_ADDR_ENTRY_DATA, {16'h0, e & 16'h83FF}, "entry");
		rchk(`ART_ADDR_STATUS, 32'h00000032, "status");
		wreg(`ART_ADDR_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		#1 chk("off", 32'(rx_override_active), 32'h0);
		chk("hold", 32'(rx_settings), 32'(e[9:0]));
		close_out;
	end
endmodule
`default_nettype wire
